// File: sbd_pkg.sv
// Purpose: shared constants and carriers for the subtract datapath
// Assumes: 8-bit data path, 16-bit instruction word
// Notes:   flag vector order is negative, sign change, zero, half, carry
package sbd_pkg;

  localparam int DATA_W      = 8;
  localparam int INSTR_W     = 16;
  localparam int BANK_W      = 4;
  localparam int ADDR_W      = BANK_W + DATA_W;
  localparam int BANK_DEPTH  = 1 << ADDR_W;

  localparam logic [5:0] OPC_REV_SUB_BORROW = 6'h15;
  localparam logic [7:0] OPC_LIT_MINUS_WORK = 8'h08;
  localparam int         DEST_BIT_POS       = 9;
  localparam int         BANK_BIT_POS       = 8;

  localparam logic [7:0] ACCESS_SPLIT      = 8'h80;
  localparam logic [3:0] ACCESS_LOW_BANK   = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK  = 4'hF;

  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [3:0] BANK_RESET = 4'h0;

  typedef struct packed {
    logic negative;
    logic sign_change;
    logic zero;
    logic half_carry;
    logic carry;
  } sbd_flags_t;

  localparam sbd_flags_t FLAGS_RESET = '0;

  typedef struct packed {
    logic [DATA_W-1:0] diff;
    sbd_flags_t        flags;
  } sbd_result_t;

  typedef enum logic [1:0] {
    SBD_OP_NONE   = 2'b00,
    SBD_OP_REVSUB = 2'b01,
    SBD_OP_LITSUB = 2'b10
  } sbd_op_t;

endpackage : sbd_pkg

// File: sbd_sub_alu.sv
// Purpose: 8-bit subtractor a - b - borrow with status flags
// Assumes: carry in is the inverted borrow
// Notes:   purely combinational
`timescale 1ns/10ps
module sbd_sub_alu
  import sbd_pkg::*;
(
  input  wire logic [DATA_W-1:0] i_minuend,
  input  wire logic [DATA_W-1:0] i_subtrahend,
  input  wire logic              i_carry_in,
  output sbd_result_t            o_result
);

  logic [DATA_W:0] full;
  logic [4:0]      low;
  logic            borrow_in;

  always_comb begin
    borrow_in = ~i_carry_in;
    full = {1'b0, i_minuend} - {1'b0, i_subtrahend}
           - {{DATA_W{1'b0}}, borrow_in};
    low  = {1'b0, i_minuend[3:0]} - {1'b0, i_subtrahend[3:0]}
           - {4'h0, borrow_in};
    o_result.diff              = full[DATA_W-1:0];
    o_result.flags.negative    = full[DATA_W-1];
    o_result.flags.zero        = (full[DATA_W-1:0] == 8'h00);
    o_result.flags.sign_change = (i_minuend[DATA_W-1]
                                  != i_subtrahend[DATA_W-1])
                                 && (full[DATA_W-1]
                                  != i_minuend[DATA_W-1]);
    o_result.flags.half_carry  = ~low[4];
    o_result.flags.carry       = ~full[DATA_W];
  end

endmodule : sbd_sub_alu

// File: sbd_core.sv
// Purpose: decode and execute two subtract instructions, one per clock
// Assumes: i_instr_valid marks a new instruction word this cycle
// Notes:   file registers held in a local array; other opcodes ignored
//
// Behaviour
// - reverse subtract computes working minus file minus inverted carry, sets flags
// - opcode top bits 010101 then destination, bank bit, 8-bit address
// - destination 0 writes working register, 1 writes the file register
// - bank bit 0 uses the access bank, ignoring bank select
// - bank bit 1 joins address with current bank select value
// - literal minus working writes working register and all five flags
`timescale 1ns/10ps
module sbd_core
  import sbd_pkg::*;
(
  input  wire logic               i_sys_clk,
  input  wire logic               i_reset_n,
  input  wire logic               i_instr_valid,
  input  wire logic [INSTR_W-1:0] i_instr,
  input  wire logic               i_bank_wr,
  input  wire logic [BANK_W-1:0]  i_bank_data,
  output logic [DATA_W-1:0]       o_working,
  output sbd_flags_t              o_flags,
  output logic [BANK_W-1:0]       o_bank,
  output logic [DATA_W-1:0]       o_file_data,
  output logic [ADDR_W-1:0]       o_file_addr,
  output logic                    o_file_wr
);

  // file registers, one array indexed by the full bank and address
  logic [DATA_W-1:0] file_mem [BANK_DEPTH];

  // architectural state
  logic [DATA_W-1:0] working_register_ff;
  sbd_flags_t        flags_ff;
  logic [BANK_W-1:0] bank_select_register_ff;

  // record of the last file write, shown at the ports
  logic [DATA_W-1:0] file_data_ff;
  logic [ADDR_W-1:0] file_addr_ff;
  logic              file_wr_ff;

  // instruction fields
  logic              dest_is_file;
  logic              use_bank_select;
  logic [DATA_W-1:0] faddr;
  logic [DATA_W-1:0] imm_value;

  // decode and operand path
  logic              is_revsub;
  logic              is_litsub;
  sbd_op_t           op;
  logic [BANK_W-1:0] access_bank;
  logic [ADDR_W-1:0] eff_addr;
  logic [DATA_W-1:0] file_val;
  logic [DATA_W-1:0] sub_a;
  logic [DATA_W-1:0] sub_b;
  logic              sub_cin;
  sbd_result_t       res;

  // write steering
  logic              to_file;
  logic              to_working;
  logic              upd_flags;

  always_comb begin
    dest_is_file    = i_instr[DEST_BIT_POS];
    use_bank_select = i_instr[BANK_BIT_POS];
    faddr           = i_instr[DATA_W-1:0];
    imm_value       = i_instr[DATA_W-1:0];
  end

  always_comb begin
    is_revsub = (i_instr[15:10] == OPC_REV_SUB_BORROW);
    is_litsub = (i_instr[15:8] == OPC_LIT_MINUS_WORK);
  end

  // any other word, or no valid word, leaves working, flags and file registers untouched
  always_comb begin
    op = SBD_OP_NONE;
    if (i_instr_valid) begin
      if (is_revsub) begin
        op = SBD_OP_REVSUB;
      end else if (is_litsub) begin
        op = SBD_OP_LITSUB;
      end
    end
  end

  // low half of the access bank sits in bank 0, high half in the
  // top bank, so the special registers stay reachable from any bank
  always_comb begin
    if (faddr < ACCESS_SPLIT) begin
      access_bank = ACCESS_LOW_BANK;
    end else begin
      access_bank = ACCESS_HIGH_BANK;
    end
  end

  always_comb begin
    if (use_bank_select) begin
      eff_addr = {bank_select_register_ff, faddr};
    end else begin
      eff_addr = {access_bank, faddr};
    end
  end

  always_comb begin
    file_val = file_mem[eff_addr];
  end

  always_comb begin
    case (op)
      SBD_OP_LITSUB: begin
        sub_a   = imm_value;
        sub_b   = working_register_ff;
        sub_cin = 1'b1;
      end
      SBD_OP_REVSUB: begin
        sub_a   = working_register_ff;
        sub_b   = file_val;
        sub_cin = flags_ff.carry;
      end
      default: begin
        sub_a   = working_register_ff;
        sub_b   = file_val;
        sub_cin = flags_ff.carry;
      end
    endcase
  end

  always_comb begin
    case (op)
      SBD_OP_REVSUB: begin
        to_file    = dest_is_file;
        to_working = !dest_is_file;
        upd_flags  = 1'b1;
      end
      SBD_OP_LITSUB: begin
        to_file    = 1'b0;
        to_working = 1'b1;
        upd_flags  = 1'b1;
      end
      default: begin
        to_file    = 1'b0;
        to_working = 1'b0;
        upd_flags  = 1'b0;
      end
    endcase
  end

  sbd_sub_alu u_alu (
    .i_minuend    (sub_a),
    .i_subtrahend (sub_b),
    .i_carry_in   (sub_cin),
    .o_result     (res)
  );

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      working_register_ff <= WORK_RESET;
    end else if (to_working) begin
      working_register_ff <= res.diff;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      flags_ff <= FLAGS_RESET;
    end else if (upd_flags) begin
      flags_ff <= res.flags;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      bank_select_register_ff <= BANK_RESET;
    end else if (i_bank_wr) begin
      bank_select_register_ff <= i_bank_data;
    end
  end

  // file array has no reset; contents are software state
  always_ff @(posedge i_sys_clk) begin
    if (to_file) begin
      file_mem[eff_addr] <= res.diff;
    end
  end

  // write strobe lasts exactly one cycle per file write
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      file_wr_ff <= 1'b0;
    end else begin
      file_wr_ff <= to_file;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      file_data_ff <= '0;
    end else if (to_file) begin
      file_data_ff <= res.diff;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      file_addr_ff <= '0;
    end else if (to_file) begin
      file_addr_ff <= eff_addr;
    end
  end

  // every output is a register copy
  assign o_working   = working_register_ff;
  assign o_flags     = flags_ff;
  assign o_bank      = bank_select_register_ff;
  assign o_file_data = file_data_ff;
  assign o_file_addr = file_addr_ff;
  assign o_file_wr   = file_wr_ff;

endmodule : sbd_core

// File: sbd_core_props.sv
// Purpose: port checker for sbd_core
// Assumes: file array contents are never visible at the ports
// Notes:   bound to every sbd_core instance
`timescale 1ns/10ps
module sbd_core_props
  import sbd_pkg::*;
(
  input wire logic               i_sys_clk,
  input wire logic               i_reset_n,
  input wire logic               i_instr_valid,
  input wire logic [INSTR_W-1:0] i_instr,
  input wire logic               i_bank_wr,
  input wire logic [BANK_W-1:0]  i_bank_data,
  input wire logic [DATA_W-1:0]  o_working,
  input wire sbd_flags_t         o_flags,
  input wire logic [BANK_W-1:0]  o_bank,
  input wire logic [DATA_W-1:0]  o_file_data,
  input wire logic [ADDR_W-1:0]  o_file_addr,
  input wire logic               o_file_wr
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  logic lit, rev, wrf;
  assign lit = i_instr_valid && i_instr[15:8] == OPC_LIT_MINUS_WORK;
  assign rev = i_instr_valid && i_instr[15:10] == OPC_REV_SUB_BORROW;
  assign wrf = rev && i_instr[DEST_BIT_POS];
  property p_lit_diff;
    lit |=> o_working == $past(i_instr[7:0]) - $past(o_working);
  endproperty
  a_lit_diff: assert property (p_lit_diff) else $error("lit diff");
  property p_lit_carry;
    lit |=> o_flags.carry == ($past(i_instr[7:0]) >= $past(o_working));
  endproperty
  a_lit_carry: assert property (p_lit_carry) else $error("carry");
  property p_wr_pulse;
    wrf |=> o_file_wr;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("no write");
  property p_no_wr;
    !wrf |=> !o_file_wr;
  endproperty
  a_no_wr: assert property (p_no_wr) else $error("stray write");
  property p_bank_sel;
    wrf && i_instr[BANK_BIT_POS] && !i_bank_wr |=>
      o_file_addr == {$past(o_bank), $past(i_instr[7:0])};
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("bank addr");
  property p_access;
    wrf && !i_instr[BANK_BIT_POS] |=> o_file_addr[ADDR_W-1:DATA_W] ==
      ($past(i_instr[7]) ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK);
  endproperty
  a_access: assert property (p_access) else $error("access addr");
  property p_refuse;
    !(lit || rev) |=> $stable(o_working) && $stable(o_flags);
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused op");
  c_lit: cover property (lit ##1 o_flags.carry == 1'b0);
  c_bank: cover property (wrf && i_instr[BANK_BIT_POS]);
  c_access: cover property (wrf && !i_instr[BANK_BIT_POS]);
endmodule : sbd_core_props
bind sbd_core sbd_core_props u_props (.*);

// File: sbd_core_tb.sv
// Purpose: directed bench for sbd_core
// Assumes: bench seeds three file registers before reset
// Notes:   literal cases run first while the working value is known
`timescale 1ns/10ps
module sbd_core_tb
  import sbd_pkg::*;
;
  logic               clk = 1'b0, rst_n = 1'b0, vld = 1'b0, bwr = 1'b0;
  logic [INSTR_W-1:0] instr = 16'h0000;
  logic [BANK_W-1:0]  bdat = 4'h0, bk;
  logic [DATA_W-1:0]  w, fd;
  sbd_flags_t         fl;
  logic [ADDR_W-1:0]  fa;
  logic               fw;
  int                 bad_count = 0, n_tests = 0;
  always #25 clk = ~clk;
  sbd_core uut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_instr_valid(vld),
    .i_instr(instr), .i_bank_wr(bwr), .i_bank_data(bdat), .o_working(w),
    .o_flags(fl), .o_bank(bk), .o_file_data(fd), .o_file_addr(fa),
    .o_file_wr(fw));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input logic [15:0] op);
    @(posedge clk);
    instr <= op;
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    #1;
  endtask : run
  task automatic t_lit;
    logic [7:0] k [5] = '{8'h02, 8'h02, 8'h01, 8'h00, 8'h7F};
    logic [7:0] e [5] = '{8'h02, 8'h00, 8'h01, 8'hFF, 8'h80};
    logic [4:0] f [5] = '{5'h03, 5'h07, 5'h03, 5'h10, 5'h1A};
    for (int i = 0; i < 5; i++) begin
      run({OPC_LIT_MINUS_WORK, k[i]});
      chk(w, e[i]);
      chk(fl, f[i]);
    end
  endtask : t_lit
  task automatic t_rev;
    @(posedge clk);
    bwr <= 1'b1;
    bdat <= 4'h3;
    @(posedge clk);
    bwr <= 1'b0;
    run(16'h5710);
    chk(fw, 16'h1);
    chk(fa, 16'h310);
    chk(fd, 16'h7A);
    chk(fl, 16'h09);
    chk(bk, 16'h3);
    run(16'h5610);
    chk(fa, 16'h010);
    chk(fd, 16'h00);
    chk(fl, 16'h07);
    run(16'h5690);
    chk(fa, 16'hF90);
    chk(fd, 16'h7F);
    chk(w, 16'h80);
    run(16'h5C00);
    chk(fw, 16'h0);
    chk(w, 16'h80);
    chk(fl, 16'h09);
    run(16'h5490);
    chk(fw, 16'h0);
    chk(fa, 16'hF90);
    chk(w, 16'h01);
    chk(fl, 16'h09);
  endtask : t_rev
  task automatic give_verdict;
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  initial begin
    uut.file_mem[12'h310] = 8'h05;
    uut.file_mem[12'h010] = 8'h80;
    uut.file_mem[12'hF90] = 8'h01;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_lit();
    t_rev();
    give_verdict();
  end
  initial begin
    repeat (500) @(posedge clk);
    bad_count++;
    give_verdict();
  end
endmodule : sbd_core_tb
